/* verilog/psl_pkg.sv */
// Purpose: shared constants and types for the port strap latch and mapper
// Assumes: 32-bit APB register access, 200 MHz system clock
// Notes: all offsets, fields and timing figures live here
package psl_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // port counts and widths
   localparam int NUM_PORTS = 4;
   localparam int IDX_W = 2;

   // port-count selection codes
   localparam logic [1:0] MODE_TWO = 2'h0;
   localparam logic [1:0] MODE_THREE_LO = 2'h1;
   localparam logic [1:0] MODE_THREE_HI = 2'h2;
   localparam logic [1:0] MODE_FOUR = 2'h3;

   // layer-select value meaning mii (zero is the lvds link type)
   localparam logic LAYER_MII = 1'h1;

   ////////////////////////////////////////////////////////////////////////////
   // register byte addresses
   localparam logic [15:0] ADDR_POWER_ON_CONFIG = 16'h0e00;
   localparam logic [15:0] ADDR_LED_FORCE = 16'h0e04;
   localparam logic [15:0] ADDR_PORT_MAP = 16'h0e08;
   localparam int ADDR_W = 16;

   // power-on config field positions
   localparam int CFG_MODE_LSB = 0;
   localparam int CFG_LAYER_LSB = 2;
   // port map status field positions
   localparam int MAP_PHYS_LSB = 0;
   localparam int MAP_ACTIVE_LSB = 8;
   localparam int MAP_MII_LSB = 12;
   localparam int MAP_DONE_BIT = 16;

   // reset values
   localparam logic [3:0] LED_FORCE_RST = 4'h0;
   localparam logic [31:0] PRDATA_RST = 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////////
   // timing
   localparam int CLK_PERIOD_PS = 5000;
   localparam int STRAP_SETTLE_NS = 100;
   localparam int SETTLE_CYC = (STRAP_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RESET_HOLD_NS = 50;
   localparam int HOLD_CYC = (RESET_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CNT_W = 8;

   ////////////////////////////////////////////////////////////////////////////
   // types
   typedef struct packed {
      logic [3:0] port_layer_select;
      logic [1:0] port_mode;
   } psl_cfg_t;

   typedef struct packed {
      logic [NUM_PORTS-1:0] log_active;
      logic [NUM_PORTS-1:0] log_mii;
      logic [NUM_PORTS*IDX_W-1:0] log_phys;
      logic [NUM_PORTS-1:0] phys_used;
      logic [NUM_PORTS-1:0] phys_mii;
      logic [NUM_PORTS*IDX_W-1:0] phys_log;
   } psl_map_t;

   typedef enum logic [1:0] {
      ST_SETTLE,
      ST_LATCH,
      ST_HOLD,
      ST_RUN
   } psl_state_t;

endpackage

/* verilog/psl_top.sv */
// Purpose: power-on strap latch and logical-to-physical port mapper
// Assumes: POR_N is the power-on reset, RST_N any later reset; straps synchronous
// Notes: latched strap value and pin functions survive RST_N
`timescale 1ns/100ps

module psl_top #(
   parameter int SETTLE_CYCLES = psl_pkg::SETTLE_CYC,
   parameter int HOLD_CYCLES = psl_pkg::HOLD_CYC
) (
   input wire logic CLK_SYS,
   input wire logic POR_N,
   input wire logic RST_N,
   // strap pins, input side
   input wire logic [1:0] MODE_PIN_IN,
   input wire logic [3:0] LAYER_PIN_IN,
   // strap pins, output side after power-on
   output logic [1:0] MODE_PIN_OUT,
   output logic [1:0] MODE_PIN_OE,
   output logic [3:0] LAYER_PIN_OUT,
   output logic [3:0] LAYER_PIN_OE,
   // core side functions of the shared pins
   input wire logic [1:0] TX_DATA_HI,
   input wire logic [3:0] LINK_ACTIVITY,
   // open-drain reset pin
   output logic RESET_PIN_OUT,
   output logic RESET_PIN_OE,
   // mapping results
   output logic [3:0] LOG_ACTIVE,
   output logic [3:0] LOG_MII,
   output logic [7:0] LOG_PHYS,
   output logic [3:0] PHYS_USED,
   output logic [3:0] PHYS_MII,
   output logic [7:0] PHYS_LOG,
   output logic CONFIG_DONE,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [15:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR
);

   ////////////////////////////////////////////////////////////////////////////
   // mapping function

   // builds both directions of the logical/physical map from captured straps
   function automatic psl_pkg::psl_map_t map_f(input psl_pkg::psl_cfg_t c);
      psl_pkg::psl_map_t m;
      logic [1:0] n_mii;
      logic [1:0] n_lvds;
      logic [1:0] total_mii;
      logic [1:0] p;
      m = '0;
      n_mii = 2'h0;
      n_lvds = 2'h0;
      total_mii = 2'h0;
      // port count decode
      m.log_active[0] = 1'b1;
      m.log_active[1] = 1'b1;
      m.log_active[2] = (c.port_mode == psl_pkg::MODE_THREE_LO) || (c.port_mode == psl_pkg::MODE_FOUR);
      m.log_active[3] = (c.port_mode == psl_pkg::MODE_THREE_HI) || (c.port_mode == psl_pkg::MODE_FOUR);
      // layer bit steering, unused ports forced clear
      m.log_mii[0] = c.port_layer_select[0] == psl_pkg::LAYER_MII;
      m.log_mii[1] = c.port_layer_select[1] == psl_pkg::LAYER_MII;
      if (c.port_mode == psl_pkg::MODE_THREE_HI) begin
         m.log_mii[3] = c.port_layer_select[2] == psl_pkg::LAYER_MII;
      end else begin
         m.log_mii[2] = m.log_active[2] && (c.port_layer_select[2] == psl_pkg::LAYER_MII);
         m.log_mii[3] = m.log_active[3] && (c.port_layer_select[3] == psl_pkg::LAYER_MII);
      end
      for (int l = 0; l < psl_pkg::NUM_PORTS; l++) begin
         if (m.log_active[l] && m.log_mii[l]) begin
            total_mii = total_mii + 2'h1;
         end
      end
      // mii ports ascend from physical 0, lvds ports follow
      for (int l = 0; l < psl_pkg::NUM_PORTS; l++) begin
         if (m.log_active[l]) begin
            if (m.log_mii[l]) begin
               p = n_mii;
               n_mii = n_mii + 2'h1;
            end else begin
               p = total_mii + n_lvds;
               n_lvds = n_lvds + 2'h1;
            end
            m.log_phys[l*psl_pkg::IDX_W +: psl_pkg::IDX_W] = p;
            m.phys_used[p] = 1'b1;
            m.phys_mii[p] = m.log_mii[l];
            m.phys_log[p*psl_pkg::IDX_W +: psl_pkg::IDX_W] = l[1:0];
         end
      end
      return m;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // declarations

   psl_pkg::psl_state_t state;
   psl_pkg::psl_state_t next_state;
   logic [psl_pkg::CNT_W-1:0] cnt;
   logic [psl_pkg::CNT_W-1:0] next_cnt;
   psl_pkg::psl_cfg_t cfg;
   psl_pkg::psl_cfg_t next_cfg;
   psl_pkg::psl_map_t map;
   logic running;
   logic [3:0] led_force;
   logic [3:0] led_level;
   logic [3:0] led_phys_act;
   logic setup_phase;
   logic access_done;
   logic hit_cfg;
   logic hit_led;
   logic hit_map;
   logic hit_any;
   logic wr_led;
   logic bad_access;
   logic [31:0] rd_mux;
   logic [31:0] map_word;

   localparam logic [psl_pkg::CNT_W-1:0] SETTLE_LAST = psl_pkg::CNT_W'(SETTLE_CYCLES - 1);
   localparam logic [psl_pkg::CNT_W-1:0] HOLD_LAST = psl_pkg::CNT_W'(HOLD_CYCLES - 1);

   ////////////////////////////////////////////////////////////////////////////
   // power-on sequence

   // settle, sample straps once, hold reset pin a little, then run
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_cfg = cfg;
      case (state)
         psl_pkg::ST_SETTLE: begin
            next_cnt = cnt + 1'b1;
            if (cnt == SETTLE_LAST) begin
               next_state = psl_pkg::ST_LATCH;
               next_cnt = '0;
            end
         end
         psl_pkg::ST_LATCH: begin
            next_cfg.port_mode = MODE_PIN_IN;
            next_cfg.port_layer_select = LAYER_PIN_IN;
            next_state = psl_pkg::ST_HOLD;
         end
         psl_pkg::ST_HOLD: begin
            next_cnt = cnt + 1'b1;
            if (cnt == HOLD_LAST) begin
               next_state = psl_pkg::ST_RUN;
               next_cnt = '0;
            end
         end
         psl_pkg::ST_RUN: begin
            next_state = psl_pkg::ST_RUN;
         end
         default: begin
            next_state = psl_pkg::ST_SETTLE;
            next_cnt = '0;
         end
      endcase
   end

   // sequencer and captured value reset only by power-on
   always_ff @(posedge CLK_SYS or negedge POR_N) begin
      if (!POR_N) begin
         state <= psl_pkg::ST_SETTLE;
         cnt <= '0;
         cfg <= '0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         cfg <= next_cfg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin functions

   // map decode and led drive level
   assign running = next_state == psl_pkg::ST_RUN;
   assign map = map_f(cfg);
   assign led_phys_act = (LINK_ACTIVITY | led_force) & map.log_active;
   assign led_level = led_phys_act ^ cfg.port_layer_select;

   // pin drivers, untouched by RST_N so warm resets keep them active
   always_ff @(posedge CLK_SYS or negedge POR_N) begin
      if (!POR_N) begin
         MODE_PIN_OUT <= '0;
         MODE_PIN_OE <= '0;
         LAYER_PIN_OUT <= '0;
         LAYER_PIN_OE <= '0;
         RESET_PIN_OUT <= 1'b0;
         RESET_PIN_OE <= 1'b1;
         CONFIG_DONE <= 1'b0;
      end else begin
         MODE_PIN_OUT <= TX_DATA_HI;
         MODE_PIN_OE <= {2{running}};
         LAYER_PIN_OUT <= led_level;
         LAYER_PIN_OE <= {4{running}};
         RESET_PIN_OUT <= 1'b0;
         RESET_PIN_OE <= !running;
         CONFIG_DONE <= running;
      end
   end

   // mapping outputs, logical view and physical view
   always_ff @(posedge CLK_SYS or negedge POR_N) begin
      if (!POR_N) begin
         LOG_ACTIVE <= '0;
         LOG_MII <= '0;
         LOG_PHYS <= '0;
         PHYS_USED <= '0;
         PHYS_MII <= '0;
         PHYS_LOG <= '0;
      end else begin
         LOG_ACTIVE <= running ? map.log_active : '0;
         LOG_MII <= running ? map.log_mii : '0;
         LOG_PHYS <= running ? map.log_phys : '0;
         PHYS_USED <= running ? map.phys_used : '0;
         PHYS_MII <= running ? map.phys_mii : '0;
         PHYS_LOG <= running ? map.phys_log : '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // apb decode

   // no wait state: data prepared in setup, answered in the first access cycle
   assign setup_phase = PSEL && !PENABLE;
   assign access_done = PSEL && PENABLE && PREADY;
   assign hit_cfg = PADDR == psl_pkg::ADDR_POWER_ON_CONFIG;
   assign hit_led = PADDR == psl_pkg::ADDR_LED_FORCE;
   assign hit_map = PADDR == psl_pkg::ADDR_PORT_MAP;
   assign hit_any = hit_cfg || hit_led || hit_map;
   assign bad_access = !hit_any || (PWRITE && !hit_led);
   assign wr_led = access_done && PWRITE && hit_led;

   // status word, every field but the done bit indexed by logical port
   assign map_word = {15'h0000, running, map.log_mii, map.log_active, map.log_phys};

   // read selection
   assign rd_mux = hit_cfg ? {26'h0000000, cfg.port_layer_select, cfg.port_mode} :
                   hit_led ? {28'h0000000, led_force} :
                   hit_map ? map_word :
                   32'h0000_0000;

   // bus response registers
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA <= psl_pkg::PRDATA_RST;
      end else begin
         PREADY <= setup_phase;
         PSLVERR <= setup_phase && bad_access;
         if (setup_phase && !PWRITE) begin
            PRDATA <= rd_mux;
         end
      end
   end

   // led force register, per logical port
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         led_force <= psl_pkg::LED_FORCE_RST;
      end else if (wr_led) begin
         led_force <= PWDATA[3:0];
      end
   end

endmodule // psl_top

/* dv/psl_strap_model.sv */
// Purpose: board strap resistors on the shared pins
// Assumes: pull level shows while the device does not drive
// Notes: driven value wins once output enable is high
`timescale 1ns/100ps
module psl_strap_model (
   input wire logic [1:0] mode_strap,
   input wire logic [3:0] layer_strap,
   input wire logic [1:0] mode_out,
   input wire logic [1:0] mode_oe,
   input wire logic [3:0] layer_out,
   input wire logic [3:0] layer_oe,
   output logic [1:0] mode_pin,
   output logic [3:0] layer_pin
);
   // pull-down reads 0, pull-up reads 1, driver overrides
   assign mode_pin = (mode_oe & mode_out) | (~mode_oe & mode_strap);
   assign layer_pin = (layer_oe & layer_out) | (~layer_oe & layer_strap);
endmodule // psl_strap_model

/* dv/psl_top_assertions.sv */
// Purpose: port checks for the strap latch and mapper
// Assumes: one clock, POR_N and RST_N active low
// Notes: bound to psl_top
`timescale 1ns/100ps
module psl_top_assertions (
   input wire logic CLK_SYS,
   input wire logic POR_N,
   input wire logic RST_N,
   input wire logic [1:0] MODE_PIN_OUT,
   input wire logic [1:0] MODE_PIN_OE,
   input wire logic [3:0] LAYER_PIN_OE,
   input wire logic [1:0] TX_DATA_HI,
   input wire logic RESET_PIN_OE,
   input wire logic [3:0] LOG_ACTIVE,
   input wire logic [3:0] LOG_MII,
   input wire logic [7:0] LOG_PHYS,
   input wire logic [3:0] PHYS_USED,
   input wire logic [3:0] PHYS_MII,
   input wire logic [7:0] PHYS_LOG,
   input wire logic CONFIG_DONE,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PREADY
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!POR_N);
   ////////////////////////////////////////
   // named steps
   sequence s_setup; PSEL && !PENABLE; endsequence
   sequence s_run2; CONFIG_DONE ##1 CONFIG_DONE; endsequence
   ////////////////////////////////////////
   a_drive_in_run: assert property (CONFIG_DONE |-> &MODE_PIN_OE && &LAYER_PIN_OE && !RESET_PIN_OE)
      else $error("pins not in operating function");
   a_straps_input: assert property (!CONFIG_DONE |-> MODE_PIN_OE == 2'h0 && LAYER_PIN_OE == 4'h0 && RESET_PIN_OE)
      else $error("strap pin driven before capture");
   a_done_kept: assert property (CONFIG_DONE |=> CONFIG_DONE)
      else $error("run state lost without power-on");
   a_map_kept: assert property (s_run2 |-> $stable(LOG_PHYS) && $stable(PHYS_LOG) && $stable(LOG_ACTIVE))
      else $error("port map changed in run");
   a_mode_pin_tx: assert property (s_run2 |-> MODE_PIN_OUT == $past(TX_DATA_HI))
      else $error("mode pin not carrying tx data");
   a_ports_paired: assert property (CONFIG_DONE |-> $countones(PHYS_USED) == $countones(LOG_ACTIVE) && LOG_ACTIVE[1:0] == 2'h3)
      else $error("logical and physical port counts differ");
   a_three_low: assert property (CONFIG_DONE && $countones(LOG_ACTIVE) == 3 |-> PHYS_USED == 4'h7)
      else $error("three-port build uses group 3");
   a_mii_low: assert property (CONFIG_DONE |-> (PHYS_MII & (PHYS_MII + 4'h1)) == 4'h0
      && $countones(PHYS_MII) == $countones(LOG_MII & LOG_ACTIVE))
      else $error("mii groups not lowest");
   a_apb_answer: assert property (@(posedge CLK_SYS) disable iff (!RST_N) s_setup |=> PREADY && PENABLE ##1 !PREADY)
      else $error("apb answer timing wrong");
endmodule // psl_top_assertions
bind psl_top psl_top_assertions u_chk (.CLK_SYS(CLK_SYS), .POR_N(POR_N), .RST_N(RST_N), .MODE_PIN_OUT(MODE_PIN_OUT),
   .MODE_PIN_OE(MODE_PIN_OE), .LAYER_PIN_OE(LAYER_PIN_OE), .TX_DATA_HI(TX_DATA_HI), .RESET_PIN_OE(RESET_PIN_OE),
   .LOG_ACTIVE(LOG_ACTIVE), .LOG_MII(LOG_MII), .LOG_PHYS(LOG_PHYS), .PHYS_USED(PHYS_USED), .PHYS_MII(PHYS_MII),
   .PHYS_LOG(PHYS_LOG), .CONFIG_DONE(CONFIG_DONE), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY));

/* dv/tb_top.sv */
// Purpose: self-checking bench for the strap latch and mapper
// Assumes: settle and hold shortened to 2 cycles
// Notes: every mode and layer strap value is swept
`timescale 1ns/100ps
module tb_top;
   logic clk = 0, por_n = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic [1:0] mstrap = 0, tx = 0, mpin, mout, moe;
   logic [3:0] lstrap = 0, act = 0, lpin, lout, loe, la, lm, pu, pm;
   logic [7:0] lph, plg;
   logic [15:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata;
   logic pready, pslverr, done, rout, roe;
   int fail_count = 0, n_compared = 0, cyc = 0;
   // 200 MHz clock
   always #2.5 clk = ~clk;
   psl_strap_model u_strap (.mode_strap(mstrap), .layer_strap(lstrap), .mode_out(mout), .mode_oe(moe),
      .layer_out(lout), .layer_oe(loe), .mode_pin(mpin), .layer_pin(lpin));
   psl_top #(.SETTLE_CYCLES(2), .HOLD_CYCLES(2)) u_dut (.CLK_SYS(clk), .POR_N(por_n), .RST_N(rst_n),
      .MODE_PIN_IN(mpin), .LAYER_PIN_IN(lpin), .MODE_PIN_OUT(mout), .MODE_PIN_OE(moe), .LAYER_PIN_OUT(lout),
      .LAYER_PIN_OE(loe), .TX_DATA_HI(tx), .LINK_ACTIVITY(act), .RESET_PIN_OUT(rout), .RESET_PIN_OE(roe),
      .LOG_ACTIVE(la), .LOG_MII(lm), .LOG_PHYS(lph), .PHYS_USED(pu), .PHYS_MII(pm), .PHYS_LOG(plg),
      .CONFIG_DONE(done), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
   // random tx data and hang guard
   always @(posedge clk) begin
      tx <= 2'($urandom);
      cyc++;
      if (cyc > 20000) begin
         fail_count++;
         report_and_stop;
      end
   end
   task report_and_stop;
      if (fail_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one apb transfer, entered just after a rising edge
   task apb(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   // reference map: mii ascending from group 0, then lvds
   task check_map(input logic [1:0] m, input logic [3:0] l, output logic [3:0] a, output logic [31:0] w);
      logic [3:0] mi, u, um;
      logic [7:0] lp, pl;
      int p;
      a = (m == 2'h0) ? 4'h3 : (m == 2'h1) ? 4'h7 : (m == 2'h2) ? 4'hb : 4'hf;
      mi = {m == 2'h2 ? l[2] : m == 2'h3 && l[3], m[0] && l[2], l[1:0]};
      p = 0;
      {lp, pl, u, um} = '0;
      for (int k = 0; k < 2; k++)
         for (int i = 0; i < 4; i++)
            if (a[i] && mi[i] == (k == 0)) begin
               lp[2*i+:2] = 2'(p);
               pl[2*p+:2] = 2'(i);
               u[p] = 1'b1;
               um[p] = (k == 0);
               p++;
            end
      chk(la, a);
      chk(lm & a, mi);
      chk(pu, u);
      chk(pm & u, um);
      for (int i = 0; i < 4; i++) begin
         if (a[i]) chk(lph[2*i+:2], lp[2*i+:2]);
         if (u[i]) chk(plg[2*i+:2], pl[2*i+:2]);
      end
      chk({rout, roe, moe, loe}, 8'h3f);
      w = {15'h0000, 1'b1, mi, a, lp};
   endtask
   // sweep straps: power-on, warm reset, leds, refusals
   initial begin
      logic [31:0] r, w;
      logic e;
      logic [3:0] a, f, l;
      logic [1:0] m;
      void'($urandom(32'hf838));
      repeat (10) @(posedge clk);
      for (int s = 0; s < 64; s++) begin
         m = 2'(s >> 4);
         l = 4'(s);
         mstrap <= m;
         lstrap <= l;
         por_n <= 1'b0;
         rst_n <= 1'b0;
         repeat (2) @(posedge clk);
         por_n <= 1'b1;
         rst_n <= 1'b1;
         for (int n = 0; n < 100 && done !== 1'b1; n++) @(posedge clk);
         check_map(m, l, a, w);
         apb(1'b0, psl_pkg::ADDR_POWER_ON_CONFIG, 32'h0, r, e);
         chk(r, {26'h0, l, m});
         chk(e, 0);
         apb(1'b0, psl_pkg::ADDR_PORT_MAP, 32'h0, r, e);
         chk(r, w);
         chk(e, 0);
         mstrap <= ~m;
         lstrap <= ~l;
         rst_n <= 1'b0;
         @(posedge clk);
         rst_n <= 1'b1;
         @(posedge clk);
         check_map(m, l, a, w);
         apb(1'b0, psl_pkg::ADDR_POWER_ON_CONFIG, 32'h0, r, e);
         chk(r, {26'h0, l, m});
         f = 4'($urandom);
         apb(1'b1, psl_pkg::ADDR_LED_FORCE, {28'h0, f}, r, e);
         act <= 4'($urandom);
         repeat (3) @(posedge clk);
         chk(lout, ((act | f) & a) ^ l);
         apb(1'b0, psl_pkg::ADDR_LED_FORCE, 32'h0, r, e);
         chk(r, {28'h0, f});
         apb(1'b1, psl_pkg::ADDR_POWER_ON_CONFIG, 32'hffff_ffff, r, e);
         chk(e, 1);
         apb(1'b0, 16'h0e10, 32'h0, r, e);
         chk(e, 1);
      end
      report_and_stop;
   end
endmodule // tb_top
